// [src/srw_clkdiv.v]
// System clock enable divider: /1, /2, optional further /16
`timescale 1ns/100ps
`default_nettype none
module srw_clkdiv (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  input  wire       ce,
  // Control
  input  wire       div1,
  input  wire       div16,
  // Enable out
  output wire       sys_en
);
  reg        half_r;
  reg  [3:0] cnt16_r;
  wire       base_en;

  assign base_en = div1 | half_r;
  assign sys_en  = base_en & (~div16 | (cnt16_r == 4'hf));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_r  <= 1'b0;
      cnt16_r <= 4'h0;
    end else if (ce) begin
      half_r <= ~half_r;
      if (base_en)
        cnt16_r <= cnt16_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [src/srw_ctrl.v]
// Stop recovery, clock divide, watchdog config and comparator output control
`include "srw_regs.vh"
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Stop-recovery register is write-only except bit 7, a read-only stop flag.
// - Clock-divide bit 1 halves system and timer clocks; 1 runs full rate.
// - Three-bit source field and level bit choose the stop wake condition.
// - Stop-delay bit 5 adds the start-up delay when leaving stop.
// - Watchdog mode register write-only, with halt and stop run enables.
// - Two-bit tap sets timeout: 512/1024/2048/8192 crystal periods; default 01.
// - Watchdog clock select: 0 internal RC by default, 1 crystal.
// - Comparator bit routes comparator results to two port-3 pins.
module srw_ctrl #(
  parameter STARTUP_CYC = `SRW_STARTUP_CYC
) (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Core power state
  input  wire        stop_req,
  input  wire        halt_mode,
  output reg         stopped,
  output reg         wake_pulse,
  output reg         startup_busy,
  // Pins
  input  wire [7:0]  port2_in,
  input  wire [2:0]  port3_in,
  input  wire [1:0]  cmp_result,
  input  wire [1:0]  port3_out_data,
  output reg  [1:0]  port3_out,
  // Clocks and watchdog config
  output wire        sys_clk_en,
  output wire        timer_clk_en,
  output reg         watchdog_run,
  output reg         watchdog_xtal_sel,
  output reg  [1:0]  watchdog_tap,
  output reg  [15:0] watchdog_cycles
);
  // Register images
  reg  [7:0]  stopcfg_r;
  reg  [7:0]  portcfg_r;
  reg  [7:0]  wdmode_r;
  reg         flag_r;
  // Stop and start-up sequencing, plus the read data mux
  reg  [15:0] dly_r;
  reg         wake_raw;
  reg         wake_cond;
  reg  [31:0] rdata_nxt;
  // Synchronised pins
  wire [7:0]  p2_s;
  wire [2:0]  p3_s;
  // Bus decode
  wire        acc;
  wire        wr;
  wire        rd;
  wire        hit_port;
  wire        hit_stop;
  wire        hit_wd;
  wire        hit_stat;
  wire        mapped;
  wire        wr_port;
  wire        wr_stop;
  wire        wr_wd;
  // Clock divider and wake decode
  wire        sys_en;
  wire        div1_en;
  wire        div16_en;
  wire [2:0]  src;
  wire        level;
  wire        stop_enter;
  wire        stop_leave;
  wire        dly_done;

  // Timeout length in crystal periods for each tap code
  function [15:0] tap_cycles;
    input [1:0] t;
    begin
      case (t)
        2'b00:   tap_cycles = `SRW_TAP0_CYC;
        2'b01:   tap_cycles = `SRW_TAP1_CYC;
        2'b10:   tap_cycles = `SRW_TAP2_CYC;
        default: tap_cycles = `SRW_TAP3_CYC;
      endcase
    end
  endfunction

  // One register word matched against the bus address
  function addr_hit;
    input [11:0] a;
    input [11:0] b;
    begin
      addr_hit = (a == b);
    end
  endfunction

  // Pins come from outside the clock domain
  srw_sync #(.W(8)) u_sync2 (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (port2_in),
    .dout    (p2_s)
  );
  srw_sync #(.W(3)) u_sync3 (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (port3_in),
    .dout    (p3_s)
  );

  // Divider runs from the stored divide bits
  assign div1_en  = stopcfg_r[`SRW_STOP_DIV1];
  assign div16_en = stopcfg_r[`SRW_STOP_DIV16];
  srw_clkdiv u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .div1    (div1_en),
    .div16   (div16_en),
    .sys_en  (sys_en)
  );
  // A frozen block issues no enables; also gated while stopped or delaying
  assign sys_clk_en   = ce & sys_en & ~stopped & ~startup_busy;
  assign timer_clk_en = sys_clk_en;

  // Zero-wait slave; unmapped addresses answer with error
  assign pready   = 1'b1;
  assign acc      = psel & penable;
  assign hit_port = addr_hit(paddr, `SRW_PORTCFG_ADDR);
  assign hit_stop = addr_hit(paddr, `SRW_STOPCFG_ADDR);
  assign hit_wd   = addr_hit(paddr, `SRW_WDMODE_ADDR);
  assign hit_stat = addr_hit(paddr, `SRW_STAT_ADDR);
  assign mapped   = hit_port | hit_stop | hit_wd | hit_stat;
  assign pslverr  = acc & ~mapped;
  // Writes need byte lane 0; reads capture data in the setup cycle
  assign wr       = acc & pwrite & ce & pstrb[0];
  assign rd       = psel & ~penable & ~pwrite & ce;
  assign wr_port  = wr & hit_port;
  assign wr_stop  = wr & hit_stop;
  assign wr_wd    = wr & hit_wd;

  // Only the stop flag and status are readable; write-only bits read zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (hit_stop)
      rdata_nxt[`SRW_STOP_FLAG] = flag_r;
    else if (hit_stat)
      rdata_nxt[2:0] = {startup_busy, stopped, flag_r};
  end

  // Read data captured in setup so it stands through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd)
      prdata <= rdata_nxt;
  end

  // Wake source select; pins arrive already synchronised
  assign src   = stopcfg_r[`SRW_STOP_SRC_LO +: 3];
  assign level = stopcfg_r[`SRW_STOP_LEVEL];
  always @* begin
    wake_raw  = 1'b0;
    wake_cond = 1'b0;
    case (src)
      3'b010:  wake_raw = p3_s[0];
      3'b011:  wake_raw = p3_s[1];
      3'b100:  wake_raw = p3_s[2];
      3'b101:  wake_raw = p2_s[7];
      3'b110:  wake_raw = ~|p2_s[3:0];
      3'b111:  wake_raw = ~|p2_s;
      default: wake_raw = 1'b0;
    endcase
    // Power-on-only codes never wake; the rest compare with the level bit
    if (src > 3'b001)
      wake_cond = (wake_raw == level);
  end

  // Stop requests are taken only while running; wakes only while stopped
  assign stop_enter = ~stopped & stop_req;
  assign stop_leave = stopped & wake_cond;
  assign dly_done   = (dly_r <= 16'h0001);

  // Stop-recovery register; bit 7 is never stored from the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stopcfg_r <= `SRW_STOPCFG_RESET;
    else if (ce) begin
      if (wr_stop)
        stopcfg_r <= {1'b0, pwdata[6:0]};
      // Recovery falls back to the halved clock
      if (stop_leave)
        stopcfg_r[`SRW_STOP_DIV1] <= 1'b0;
    end
  end

  // Port configuration: only the comparator routing bit is used here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      portcfg_r <= `SRW_PORTCFG_RESET;
    else if (ce && wr_port)
      portcfg_r <= pwdata[7:0];
  end

  // Watchdog mode: tap, halt and stop run enables, clock source
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wdmode_r <= `SRW_WDMODE_RESET;
    else if (ce && wr_wd)
      wdmode_r <= pwdata[7:0];
  end

  // Stop flag: cleared only by reset, set by every recovery
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flag_r <= 1'b0;
    else if (ce && stop_leave)
      flag_r <= 1'b1;
  end

  // Stop state and one-cycle wake pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stopped    <= 1'b0;
      wake_pulse <= 1'b0;
    end else if (ce) begin
      wake_pulse <= 1'b0;
      if (stop_enter)
        stopped <= 1'b1;
      else if (stop_leave) begin
        stopped    <= 1'b0;
        wake_pulse <= 1'b1;
      end
    end
  end

  // Start-up delay counts down after a recovery with the delay bit set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_busy <= 1'b0;
      dly_r        <= 16'h0000;
    end else if (ce) begin
      if (stop_leave && stopcfg_r[`SRW_STOP_DELAY]) begin
        startup_busy <= 1'b1;
        dly_r        <= STARTUP_CYC[15:0];
      end else if (startup_busy) begin
        if (dly_done)
          startup_busy <= 1'b0;
        dly_r <= dly_r - 16'h0001;
      end
    end
  end

  // Port 3 outputs: standard data or the comparator results
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      port3_out <= 2'b00;
    else if (ce)
      port3_out <= portcfg_r[`SRW_PORT_CMP] ? cmp_result : port3_out_data;
  end

  // Watchdog keeps counting in halt or stop only when enabled for it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      watchdog_run <= 1'b0;
    else if (ce) begin
      if (stopped)
        watchdog_run <= wdmode_r[`SRW_WD_STOP];
      else if (halt_mode)
        watchdog_run <= wdmode_r[`SRW_WD_HALT];
      else
        watchdog_run <= 1'b1;
    end
  end

  // Timeout config only; the counter itself lives outside this block
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_xtal_sel <= 1'b0;
      watchdog_tap      <= 2'b01;
      watchdog_cycles   <= `SRW_TAP1_CYC;
    end else if (ce) begin
      watchdog_xtal_sel <= wdmode_r[`SRW_WD_XTAL];
      watchdog_tap      <= wdmode_r[`SRW_WD_TAP_LO +: 2];
      watchdog_cycles   <= tap_cycles(wdmode_r[`SRW_WD_TAP_LO +: 2]);
    end
  end
endmodule
`default_nettype wire

// [src/srw_regs.vh]
// Register offsets, field positions, reset values and timing counts
`ifndef SRW_REGS_VH
`define SRW_REGS_VH
`define SRW_PORTCFG_ADDR   12'h000
`define SRW_STOPCFG_ADDR   12'h02c
`define SRW_WDMODE_ADDR    12'h03c
`define SRW_STAT_ADDR      12'h040
`define SRW_PORTCFG_IDX    8'h00
`define SRW_STOPCFG_IDX    8'h0b
`define SRW_WDMODE_IDX     8'h0f
`define SRW_STOP_DIV16     0
`define SRW_STOP_DIV1      1
`define SRW_STOP_SRC_LO    2
`define SRW_STOP_DELAY     5
`define SRW_STOP_LEVEL     6
`define SRW_STOP_FLAG      7
`define SRW_PORT_CMP       0
`define SRW_WD_TAP_LO      0
`define SRW_WD_HALT        2
`define SRW_WD_STOP        3
`define SRW_WD_XTAL        4
`define SRW_STOPCFG_RESET  8'h00
`define SRW_PORTCFG_RESET  8'h00
`define SRW_WDMODE_RESET   8'h01
`define SRW_STARTUP_CYC    16'd1024
`define SRW_TAP0_CYC       16'd512
`define SRW_TAP1_CYC       16'd1024
`define SRW_TAP2_CYC       16'd2048
`define SRW_TAP3_CYC       16'd8192
`endif

// [src/srw_sync.v]
// Three-stage input synchroniser, change accepted when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module srw_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  input  wire         ce,
  // Data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1)
        if (s2_r[i] == s3_r[i])
          dout[i] <= s3_r[i];
    end
  end
endmodule
`default_nettype wire

// [tb/srw_ctrl_props.sv]
// Port-level checks on the stop recovery and watchdog control block
`timescale 1ns/100ps
`default_nettype none
module srw_ctrl_props (
  // Clock, reset and bus
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Power state
  input  wire logic        stop_req,
  input  wire logic        stopped,
  input  wire logic        wake_pulse,
  input  wire logic        startup_busy,
  // Watchdog config
  input  wire logic [1:0]  watchdog_tap,
  input  wire logic        watchdog_xtal_sel,
  input  wire logic [15:0] watchdog_cycles
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr == 12'h000 || paddr == 12'h02c || paddr == 12'h03c || paddr == 12'h040;
  wire wdm_wr = psel && penable && pwrite && ce && pstrb[0] && paddr == 12'h03c;
  wire [15:0] tap_exp = (watchdog_tap == 2'h3) ? 16'h2000 : (16'h0200 << watchdog_tap);
  chk_ready_high: assert property (pready)
    else $error("ready low");
  chk_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped access");
  chk_tap_cycles: assert property (watchdog_cycles == tap_exp)
    else $error("timeout count wrong for tap");
  chk_tap_write: assert property (wdm_wr |-> ##2 watchdog_tap == $past(pwdata[1:0], 2))
    else $error("tap not written");
  chk_sel_write: assert property (wdm_wr |-> ##2 watchdog_xtal_sel == $past(pwdata[4], 2))
    else $error("clock select not written");
  chk_wake_once: assert property (ce && wake_pulse |=> !wake_pulse)
    else $error("wake pulse too long");
  chk_wake_leaves: assert property (wake_pulse |-> !stopped)
    else $error("still stopped at wake");
  chk_stop_enter: assert property (ce && stop_req && !stopped && !wake_pulse |=> stopped)
    else $error("stop not entered");
endmodule
`default_nettype wire

// [tb/srw_pin_model.sv]
// Wake pin driver that holds its active level well past the minimum width
`timescale 1ns/100ps
`default_nettype none
module srw_pin_model (
  // Clock and command
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic       lvl,
  // Pins
  output wire logic [7:0] port2_in,
  output wire logic [2:0] port3_in
);
  logic [3:0] hold_r = 4'h0;
  // Eight clocks active, comfortably above three periods
  always @(posedge pclk) begin
    if (go)
      hold_r <= 4'h8;
    else if (hold_r != 4'h0)
      hold_r <= hold_r - 4'h1;
  end
  assign port3_in = (hold_r != 4'h0) ? {3{lvl}} : {3{~lvl}};
  assign port2_in = {8{~lvl}};
endmodule
`default_nettype wire

// [tb/tb_srw_ctrl.sv]
// Self-checking bench for the stop recovery and watchdog control block
`timescale 1ns/100ps
`default_nettype none
module tb_srw_ctrl;
  logic        pclk, presetn, ce, psel, penable, pwrite, stop_req, halt_mode, go, err;
  logic        pready, pslverr, stopped, wake_pulse, startup_busy, sys_clk_en;
  logic        timer_clk_en, watchdog_run, watchdog_xtal_sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  port2_in;
  logic [2:0]  port3_in;
  logic [1:0]  port3_out, watchdog_tap, cmp;
  logic [15:0] watchdog_cycles;
  int          n_fail = 0, tests_run = 0;
  // Watchdog mode byte beside its timeout count
  logic [23:0] rows [4] = '{24'h040200, 24'h110400, 24'h060800, 24'h132000};
  srw_ctrl #(.STARTUP_CYC(8)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .stop_req(stop_req),
    .halt_mode(halt_mode), .stopped(stopped), .wake_pulse(wake_pulse),
    .startup_busy(startup_busy), .port2_in(port2_in), .port3_in(port3_in),
    .cmp_result(cmp), .port3_out_data(2'h2), .port3_out(port3_out),
    .sys_clk_en(sys_clk_en), .timer_clk_en(timer_clk_en), .watchdog_run(watchdog_run),
    .watchdog_xtal_sel(watchdog_xtal_sel), .watchdog_tap(watchdog_tap),
    .watchdog_cycles(watchdog_cycles));
  srw_pin_model i_pins (.pclk(pclk), .go(go), .lvl(1'b1), .port2_in(port2_in),
    .port3_in(port3_in));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task test_done;
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Enable pulses over 32 clocks; a timer count of 0 skips that check
  task rate(input logic [31:0] es, input logic [31:0] et);
    logic [31:0] ns, nt;
    ns = 0;
    nt = 0;
    repeat (32) begin
      @(posedge pclk);
      ns = ns + sys_clk_en;
      nt = nt + timer_clk_en;
    end
    chk("sys_clk_en count", es, ns);
    if (et != 0) chk("timer_clk_en count", et, nt);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, stop_req, go, paddr, pwdata} = '0;
    ce = 1'b1;
    cmp = 2'h1;
    halt_mode = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rate(16, 16);
    chk("port3_out", 2'h2, port3_out);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h03c, rows[i][23:16]);
      repeat (2) @(posedge pclk);
      chk("watchdog_tap", rows[i][17:16], watchdog_tap);
      chk("watchdog_cycles", rows[i][15:0], watchdog_cycles);
      chk("watchdog_xtal_sel", rows[i][20], watchdog_xtal_sel);
      chk("watchdog_run", rows[i][18], watchdog_run);
    end
    halt_mode <= 1'b0;
    apb(1'b1, 12'h000, 8'h01);
    repeat (2) @(posedge pclk);
    chk("port3_out", 2'h1, port3_out);
    cmp <= 2'h3;
    repeat (2) @(posedge pclk);
    chk("port3_out", 2'h3, port3_out);
    apb(1'b0, 12'h010, 8'h00);
    chk("pslverr", 1, err);
    apb(1'b1, 12'h02c, 8'h81);
    rate(1, 0);
    apb(1'b0, 12'h040, 8'h00);
    chk("stop flag", 0, rd[0]);
    // Wake on port3_in bit 0 high, delay on, full rate until stop
    apb(1'b1, 12'h02c, 8'h6a);
    rate(32, 32);
    stop_req <= 1'b1;
    do @(posedge pclk); while (stopped !== 1'b1);
    stop_req <= 1'b0;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do @(posedge pclk); while (wake_pulse !== 1'b1);
    @(posedge pclk);
    chk("startup_busy", 1, startup_busy);
    do @(posedge pclk); while (startup_busy !== 1'b0);
    apb(1'b0, 12'h040, 8'h00);
    chk("stop flag", 1, rd[0]);
    rate(16, 16);
    // Clock enable low: no enables and a write must not land
    ce <= 1'b0;
    apb(1'b1, 12'h03c, 8'h02);
    rate(0, 0);
    ce <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("watchdog_tap", 2'h3, watchdog_tap);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("watchdog_tap", 2'h1, watchdog_tap);
    chk("watchdog_xtal_sel", 0, watchdog_xtal_sel);
    presetn <= 1'b1;
    apb(1'b0, 12'h040, 8'h00);
    chk("stop flag", 0, rd[0]);
    test_done();
  end
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
endmodule
bind srw_ctrl srw_ctrl_props i_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .stop_req(stop_req), .stopped(stopped),
  .wake_pulse(wake_pulse), .startup_busy(startup_busy), .watchdog_tap(watchdog_tap),
  .watchdog_xtal_sel(watchdog_xtal_sel), .watchdog_cycles(watchdog_cycles));
`default_nettype wire
